//--- core/alu_pkg.sv
// package of the integer and decimal arithmetic unit: types, register map, constants
// assumes a single core clock and a decoder that issues one operation at a time
package alu_pkg;

  // ----------------------------------------------------------------
  // widths and register map
  // ----------------------------------------------------------------
  localparam int             DATA_W        = 32;
  localparam int             REG_ADDR_W    = 4;
  localparam int             FLAGS_W       = 6;
  localparam logic [3:0]     REG_FLAGS     = 4'h0;
  localparam logic [3:0]     REG_STATUS    = 4'h4;
  localparam logic [3:0]     REG_RESULT    = 4'h8;
  localparam logic [3:0]     REG_RESULT_HI = 4'hC;

  // ----------------------------------------------------------------
  // decimal constants
  // ----------------------------------------------------------------
  localparam logic [3:0]     DIGIT_MAX     = 4'h9;
  localparam logic [7:0]     PACKED_MAX    = 8'h99;
  localparam logic [7:0]     LOW_ADJUST    = 8'h06;
  localparam logic [7:0]     HIGH_ADJUST   = 8'h60;
  localparam logic [7:0]     DIGIT_MASK    = 8'h0F;
  localparam logic [7:0]     DECIMAL_BASE  = 8'h0A;
  localparam logic [7:0]     BYTE_ONE      = 8'h01;

  // ----------------------------------------------------------------
  // operations, sizes, flags
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    plain_sum, sum_with_carry_in, plain_difference, difference_with_borrow_in,
    plus_one_op, minus_one_op, compare_flags_only, sign_flip,
    unsigned_product, signed_product, unsigned_quotient, signed_quotient,
    packed_decimal_fix_after_sum, packed_decimal_fix_after_difference,
    unpacked_fix_after_sum, unpacked_fix_after_difference,
    unpacked_split_after_product, unpacked_merge_before_quotient,
    bit_and, bit_or, bit_xor, bit_invert
  } op_t;

  typedef enum logic [1:0] {size_byte, size_word, size_dword} size_t;

  typedef enum logic [1:0] {ph_idle, ph_product, ph_quotient} phase_t;

  typedef struct packed {
    logic overflow_flag;
    logic sign_flag;
    logic zero_flag;
    logic auxiliary_carry_flag;
    logic parity_flag;
    logic carry_flag;
  } flags_t;

  typedef struct packed {
    op_t               op;
    size_t             size;
    logic              keep_low_only;
    logic [DATA_W-1:0] first;
    logic [DATA_W-1:0] second;
  } issue_t;

  typedef struct packed {
    logic [DATA_W-1:0] value;
    logic [DATA_W-1:0] high;
    logic              write_value;
    logic              write_high;
    logic              fault;
    flags_t            flags;
  } result_t;

  typedef struct packed {
    phase_t            phase;
    flags_t            flags;
    result_t           result;
    logic              done;
    issue_t            job;
    logic [DATA_W-1:0] rem;
    logic [DATA_W-1:0] dq;
    logic [DATA_W-1:0] divisor;
    logic [5:0]        steps;
    logic              q_neg;
    logic              r_neg;
    logic [DATA_W-1:0] rdata;
  } state_t;

  localparam state_t STATE_RESET = '0;

endpackage

//--- core/integer_and_bcd_arithmetic_unit.sv
// integer, decimal and Boolean arithmetic unit with its own status flags
// assumes the decoder holds issue_i stable while issue_valid_i is high and
// takes result_o only in the cycle done_o is high
`timescale 1ns/100ps

//   Function
// (RQ1) operands are 8, 16 or 32 bits, signed or unsigned
// (RQ2) sum and difference share one binary adder for both signednesses
// (RQ3) sum with carry adds one more when carry flag set
// (RQ4) difference with borrow subtracts one more when carry flag set
// (RQ5) increment adds one, decrement subtracts one
// (RQ6) compare sets all six flags from the difference
// (RQ7) compare writes no result, only flags change
// (RQ8) sign flip yields zero minus operand
// (RQ9) unsigned product is double width
// (RQ10) signed product double width, truncated form keeps low half only
// (RQ11) unsigned quotient returns quotient and remainder
// (RQ12) signed quotient as unsigned one but on signed values
// (RQ13) packed fix after sum corrects low byte, carry on decimal carry
// (RQ14) packed fix after difference corrects low byte, carry on borrow
// (RQ15) unpacked fix after sum: digit in low nibble, carry bumps high byte
// (RQ16) unpacked fix after difference: borrow sets carry, decrements high byte
// (RQ17) split after product: units to low byte, tens to high byte
// (RQ18) merge before quotient: tens times ten plus units into low byte
// (RQ19) bitwise and, or, xor on two operands
// (RQ20) inversion complements every bit of one operand
// (RQ21) arithmetic ops update flags like compare, carry is carry or borrow; products set overflow and carry from the high half, quotients keep the flags
// (RQ22) multi-cycle ops signal done when result and flags commit
module integer_and_bcd_arithmetic_unit (
  input  wire logic                           clock_i,
  input  wire logic                           reset_i,
  input  wire logic                           issue_valid_i,
  input  wire alu_pkg::issue_t                issue_i,
  output logic                                issue_ready_o,
  output logic                                done_o,
  output alu_pkg::result_t                    result_o,
  input  wire logic [alu_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input  wire logic [alu_pkg::DATA_W-1:0]     reg_wdata_i,
  input  wire logic                           reg_write_i,
  input  wire logic                           reg_read_i,
  output logic [alu_pkg::DATA_W-1:0]          reg_rdata_o
);
  import alu_pkg::*;

  // ----------------------------------------------------------------
  // size helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] mask_of(size_t s);
    unique case (s)
      size_byte: return 32'h0000_00FF; // RQ1
      size_word: return 32'h0000_FFFF;
      default:   return 32'hFFFF_FFFF;
    endcase
  endfunction

  function automatic logic [5:0] width_of(size_t s);
    unique case (s)
      size_byte: return 6'h08;
      size_word: return 6'h10;
      default:   return 6'h20;
    endcase
  endfunction

  function automatic logic msb_of(logic [31:0] v, size_t s);
    unique case (s)
      size_byte: return v[7];
      size_word: return v[15];
      default:   return v[31];
    endcase
  endfunction

  function automatic logic [31:0] sext(logic [31:0] v, size_t s);
    unique case (s)
      size_byte: return {{24{v[7]}}, v[7:0]};
      size_word: return {{16{v[15]}}, v[15:0]};
      default:   return v;
    endcase
  endfunction

  function automatic logic [31:0] magnitude(logic [31:0] v, size_t s, logic sgn);
    logic [31:0] m;
    m = mask_of(s);
    return (sgn && msb_of(v, s)) ? ((32'h0 - v) & m) : (v & m);
  endfunction

  // ----------------------------------------------------------------
  // flag helpers
  // ----------------------------------------------------------------
  function automatic flags_t status_of(logic [31:0] r, size_t s,
                                       logic ov, logic ax, logic cy);
    flags_t f;
    f.overflow_flag        = ov;
    f.sign_flag            = msb_of(r, s);
    f.zero_flag            = ((r & mask_of(s)) == 32'h0);
    f.auxiliary_carry_flag = ax;
    f.parity_flag          = ~^r[7:0];
    f.carry_flag           = cy;
    return f;
  endfunction

  function automatic flags_t add_flags(logic [31:0] a, logic [31:0] bx,
                                       logic [32:0] sum, size_t s, logic sub);
    logic [31:0] r;
    logic        ov;
    r  = sum[31:0] & mask_of(s);
    ov = (msb_of(a, s) == msb_of(bx, s)) && (msb_of(r, s) != msb_of(a, s));
    return status_of(r, s, ov, a[4] ^ bx[4] ^ r[4] ^ sub,
                     sum[width_of(s)] ^ sub); // RQ6 RQ21
  endfunction

  // ----------------------------------------------------------------
  // single-cycle operations
  // ----------------------------------------------------------------
  function automatic result_t run_quick(issue_t q, flags_t f);
    logic [31:0] m;
    logic [31:0] a;
    logic [31:0] bx;
    logic [31:0] be;
    logic [32:0] sum;
    logic        sub;
    logic        cin;
    logic [7:0]  al;
    logic [7:0]  ah;
    logic        low_fix;
    logic        high_fix;
    result_t     o;
    m        = mask_of(q.size);
    a        = q.first & m;
    bx       = q.second & m;
    sub      = 1'b0;
    cin      = 1'b0;
    al       = q.first[7:0];
    ah       = q.first[15:8];
    low_fix  = (al[3:0] > DIGIT_MAX) || f.auxiliary_carry_flag;
    high_fix = (al > PACKED_MAX) || f.carry_flag;
    o             = '0;
    o.write_value = 1'b1;
    unique case (q.op)
      sum_with_carry_in:         cin = f.carry_flag; // RQ3
      plain_difference:          sub = 1'b1; // RQ2
      compare_flags_only:        sub = 1'b1; // RQ6
      difference_with_borrow_in:
      begin
        sub = 1'b1;
        cin = f.carry_flag; // RQ4
      end
      plus_one_op:               bx = 32'h1; // RQ5
      minus_one_op:
      begin
        sub = 1'b1;
        bx  = 32'h1; // RQ5
      end
      sign_flip:
      begin
        sub = 1'b1;
        bx  = a;
        a   = 32'h0; // RQ8
      end
      default: ;
    endcase
    // one adder: a + b + cin, or a + ~b + ~cin for differences
    be      = (sub ? ~bx : bx) & m; // RQ2
    sum     = {1'b0, a} + {1'b0, be} + {32'h0, sub ^ cin};
    o.value = sum[31:0] & m;
    o.flags = add_flags(a, be, sum, q.size, sub); // RQ21
    unique case (q.op)
      compare_flags_only: o.write_value = 1'b0; // RQ7
      bit_and: o.value = a & bx; // RQ19
      bit_or:  o.value = a | bx; // RQ19
      bit_xor: o.value = a ^ bx; // RQ19
      bit_invert:
      begin
        o.value = ~q.first & m; // RQ20
        o.flags = f;
      end
      packed_decimal_fix_after_sum:
      begin
        al = al + (low_fix ? LOW_ADJUST : 8'h00) + (high_fix ? HIGH_ADJUST : 8'h00); // RQ13
        o.flags = status_of({24'h0, al}, size_byte, 1'b0, low_fix, high_fix);
      end
      packed_decimal_fix_after_difference:
      begin
        o.flags = status_of(32'h0, size_byte, 1'b0, low_fix,
                            high_fix || (low_fix && al < LOW_ADJUST)); // RQ14
        al = al - (low_fix ? LOW_ADJUST : 8'h00) - (high_fix ? HIGH_ADJUST : 8'h00);
        o.flags = status_of({24'h0, al}, size_byte, 1'b0, low_fix, o.flags.carry_flag);
      end
      unpacked_fix_after_sum:
      begin
        al = (al + (low_fix ? LOW_ADJUST : 8'h00)) & DIGIT_MASK; // RQ15
        ah = ah + (low_fix ? BYTE_ONE : 8'h00);
        o.flags = status_of({24'h0, al}, size_byte, 1'b0, low_fix, low_fix);
      end
      unpacked_fix_after_difference:
      begin
        al = (al - (low_fix ? LOW_ADJUST : 8'h00)) & DIGIT_MASK; // RQ16
        ah = ah - (low_fix ? BYTE_ONE : 8'h00);
        o.flags = status_of({24'h0, al}, size_byte, 1'b0, low_fix, low_fix);
      end
      unpacked_split_after_product:
      begin
        ah = al / DECIMAL_BASE; // RQ17
        al = al % DECIMAL_BASE;
        o.flags = status_of({24'h0, al}, size_byte, 1'b0, 1'b0, 1'b0);
      end
      unpacked_merge_before_quotient:
      begin
        al = 8'(ah * DECIMAL_BASE + al); // RQ18
        ah = 8'h00;
        o.flags = status_of({24'h0, al}, size_byte, 1'b0, 1'b0, 1'b0);
      end
      default: ;
    endcase
    if (q.op inside {packed_decimal_fix_after_sum, packed_decimal_fix_after_difference,
                     unpacked_fix_after_sum, unpacked_fix_after_difference,
                     unpacked_split_after_product, unpacked_merge_before_quotient})
    begin
      o.value = {q.first[31:16], ah, al};
    end
    if (q.op inside {bit_and, bit_or, bit_xor})
    begin
      o.flags = status_of(o.value, q.size, 1'b0, 1'b0, 1'b0);
    end
    return o;
  endfunction

  // ----------------------------------------------------------------
  // product stage
  // ----------------------------------------------------------------
  function automatic result_t run_product(issue_t q, flags_t f);
    logic [31:0] m;
    logic [31:0] sa;
    logic [31:0] sb;
    logic [63:0] p;
    logic [31:0] lo;
    logic [31:0] hi;
    logic        sgn;
    logic        wide;
    result_t     o;
    m   = mask_of(q.size);
    sgn = (q.op == signed_product);
    sa  = sgn ? sext(q.first, q.size) : (q.first & m);
    sb  = sgn ? sext(q.second, q.size) : (q.second & m);
    if (sgn)
    begin
      p = 64'($signed({{32{sa[31]}}, sa}) * $signed({{32{sb[31]}}, sb}));
    end
    else
    begin
      p = {32'h0, sa} * {32'h0, sb}; // RQ9
    end
    lo   = p[31:0] & m;
    hi   = 32'(p >> width_of(q.size)) & m;
    wide = sgn ? (hi != (msb_of(lo, q.size) ? m : 32'h0)) : (hi != 32'h0);
    o             = '0;
    o.value       = lo;
    o.high        = hi;
    o.write_value = 1'b1;
    o.write_high  = !(sgn && q.keep_low_only); // RQ10
    o.flags       = status_of(lo, q.size, wide, f.auxiliary_carry_flag, wide);
    return o;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_t      s;
  state_t      next_s;
  logic [32:0] rem_sh;
  logic [31:0] q_mag;
  logic [31:0] r_mag;
  logic [31:0] mag_a;
  logic [31:0] mag_b;
  logic [31:0] top;
  logic        sgn;

  always_comb
  begin
    next_s      = s;
    rem_sh      = '0;
    q_mag       = '0;
    r_mag       = '0;
    mag_a       = '0;
    mag_b       = '0;
    top         = '0;
    sgn         = 1'b0;
    next_s.done = 1'b0;
    // register port
    next_s.rdata = '0;
    if (reg_write_i && reg_addr_i == REG_FLAGS)
    begin
      next_s.flags = flags_t'(reg_wdata_i[FLAGS_W-1:0]);
    end
    if (reg_read_i)
    begin
      unique case (reg_addr_i)
        REG_FLAGS:     next_s.rdata = {26'h0, s.flags};
        REG_STATUS:    next_s.rdata = {30'h0, s.result.fault, s.phase != ph_idle};
        REG_RESULT:    next_s.rdata = s.result.value;
        REG_RESULT_HI: next_s.rdata = s.result.high;
        default:       next_s.rdata = '0;
      endcase
    end
    // sequencing
    unique case (s.phase)
      ph_idle:
      if (issue_valid_i)
      begin
        next_s.job = issue_i;
        if (issue_i.op inside {unsigned_product, signed_product})
        begin
          next_s.phase = ph_product;
        end
        else if (issue_i.op inside {unsigned_quotient, signed_quotient})
        begin
          sgn   = (issue_i.op == signed_quotient); // RQ12
          mag_a = magnitude(issue_i.first, issue_i.size, sgn);
          mag_b = magnitude(issue_i.second, issue_i.size, sgn);
          if (mag_b == 32'h0)
          begin
            next_s.result       = '0;
            next_s.result.fault = 1'b1;
            next_s.result.flags = s.flags;
            next_s.done         = 1'b1;
          end
          else
          begin
            next_s.dq      = mag_a << (6'h20 - width_of(issue_i.size));
            next_s.rem     = '0;
            next_s.divisor = mag_b;
            next_s.steps   = width_of(issue_i.size);
            next_s.q_neg   = sgn && (msb_of(issue_i.first, issue_i.size)
                                     ^ msb_of(issue_i.second, issue_i.size));
            next_s.r_neg   = sgn && msb_of(issue_i.first, issue_i.size);
            next_s.phase   = ph_quotient;
          end
        end
        else
        begin
          next_s.result = run_quick(issue_i, s.flags);
          next_s.done   = 1'b1;
        end
      end
      ph_product:
      begin
        next_s.result = run_product(s.job, s.flags);
        next_s.done   = 1'b1; // RQ22
        next_s.phase  = ph_idle;
      end
      ph_quotient:
      begin
        // restoring divide, one quotient bit a cycle
        rem_sh = {s.rem, s.dq[31]};
        if (rem_sh >= {1'b0, s.divisor})
        begin
          next_s.rem = 32'(rem_sh - {1'b0, s.divisor});
          next_s.dq  = {s.dq[30:0], 1'b1};
        end
        else
        begin
          next_s.rem = rem_sh[31:0];
          next_s.dq  = {s.dq[30:0], 1'b0};
        end
        next_s.steps = s.steps - 6'h01;
        if (s.steps == 6'h01)
        begin
          q_mag = next_s.dq & mask_of(s.job.size);
          r_mag = next_s.rem;
          top   = 32'h1 << (width_of(s.job.size) - 6'h01);
          next_s.result             = '0;
          next_s.result.value       = s.q_neg ? ((32'h0 - q_mag) & mask_of(s.job.size))
                                              : q_mag; // RQ11
          next_s.result.high        = s.r_neg ? ((32'h0 - r_mag) & mask_of(s.job.size))
                                              : r_mag; // RQ11
          next_s.result.fault       = (s.job.op == signed_quotient)
                                      && (s.q_neg ? (q_mag > top) : (q_mag >= top)); // RQ12
          next_s.result.write_value = !next_s.result.fault;
          next_s.result.write_high  = !next_s.result.fault;
          next_s.result.flags       = s.flags;
          next_s.done               = 1'b1; // RQ22
          next_s.phase              = ph_idle;
        end
      end
      default: next_s.phase = ph_idle;
    endcase
    // flags commit with the result; hardware update wins over a write
    if (next_s.done)
    begin
      next_s.flags = next_s.result.flags; // RQ21
    end
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s <= STATE_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign issue_ready_o = (s.phase == ph_idle);
  assign done_o        = s.done;
  assign result_o      = s.result;
  assign reg_rdata_o   = s.rdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);

  logic taken;
  assign taken = issue_valid_i && issue_ready_o;

  a_sum_value: assert property (taken && issue_i.op == plain_sum // RQ2
      && issue_i.size == size_dword |=> done_o
      && result_o.value == $past(issue_i.first + issue_i.second))
    else $error("plain sum wrong");
  a_carry_chain: assert property (taken && issue_i.op == sum_with_carry_in // RQ3
      && issue_i.size == size_dword |=> result_o.value
      == $past(issue_i.first + issue_i.second + {31'h0, s.flags.carry_flag}))
    else $error("carry not chained");
  a_borrow_chain: assert property (taken // RQ4
      && issue_i.op == difference_with_borrow_in && issue_i.size == size_dword
      |=> result_o.value
      == $past(issue_i.first - issue_i.second - {31'h0, s.flags.carry_flag}))
    else $error("borrow not chained");
  a_step_one: assert property (taken && issue_i.op == minus_one_op // RQ5
      && issue_i.size == size_word |=> result_o.value[15:0]
      == 16'($past(issue_i.first[15:0]) - 16'h0001))
    else $error("decrement wrong");
  a_compare_quiet: assert property (taken && issue_i.op == compare_flags_only // RQ7
      && issue_i.size == size_dword |=> done_o && !result_o.write_value
      && s.flags.zero_flag == ($past(issue_i.first) == $past(issue_i.second)))
    else $error("compare wrote a result");
  a_flip_sign: assert property (taken && issue_i.op == sign_flip // RQ8
      && issue_i.size == size_dword |=> result_o.value == 32'h0 - $past(issue_i.first))
    else $error("negation wrong");
  a_product_wide: assert property (taken && issue_i.op == unsigned_product // RQ9
      && issue_i.size == size_word |=> !done_o ##1 done_o
      && {result_o.high[15:0], result_o.value[15:0]}
      == $past(32'(issue_i.first[15:0]) * 32'(issue_i.second[15:0]), 2))
    else $error("product not double width");
  a_quotient_time: assert property (taken && issue_i.op == unsigned_quotient // RQ11
      && issue_i.size == size_byte && issue_i.second[7:0] != 8'h00
      |=> !done_o [*8] ##1 done_o
      && result_o.value[7:0] == $past(issue_i.first[7:0] / issue_i.second[7:0], 9))
    else $error("quotient late or wrong");
  a_digit_clear: assert property (taken && issue_i.op == unpacked_fix_after_sum // RQ15
      |=> result_o.value[7:4] == 4'h0
      && result_o.value[15:8] == $past(issue_i.first[15:8]) + {7'h0, s.flags.carry_flag})
    else $error("unpacked sum fix wrong");
  a_split_digits: assert property (taken // RQ17
      && issue_i.op == unpacked_split_after_product |=> result_o.value[15:0]
      == {$past(issue_i.first[7:0]) / 8'h0A, $past(issue_i.first[7:0]) % 8'h0A})
    else $error("split digits wrong");

endmodule // integer_and_bcd_arithmetic_unit

//--- sim/issue_source.sv
// decoder model that feeds the arithmetic unit's issue port
// assumes calls are made right after a rising clock edge
`timescale 1ns/100ps
module issue_source (
  input  wire logic      clock_i,
  input  wire logic      issue_ready_i,
  output logic           issue_valid_o,
  output alu_pkg::issue_t issue_o
);
  import alu_pkg::*;
  // ----------------------------------------
  // request hold and release
  // ----------------------------------------
  initial
  begin
    issue_valid_o = 1'b0;
    issue_o       = '0;
  end
  // holds the request until ready is seen at an edge
  task automatic send(input issue_t job);
    issue_o       <= job;
    issue_valid_o <= 1'b1;
    @(posedge clock_i);
    while (issue_ready_i !== 1'b1)
      @(posedge clock_i);
  endtask
  // released operands no longer show the last value
  task automatic idle();
    issue_valid_o  <= 1'b0;
    issue_o.first  <= ~issue_o.first;
    issue_o.second <= ~issue_o.second;
  endtask
endmodule // issue_source

//--- sim/test_integer_and_bcd_arithmetic_unit.sv
// self-checking bench for the integer and decimal arithmetic unit
// assumes the issue_source decoder model and a 250 MHz core clock
`timescale 1ns/100ps
module test_integer_and_bcd_arithmetic_unit;
  import alu_pkg::*;
  typedef struct {logic [31:0] v, vm, h, hm; logic [5:0] f, fm;} note_t;
  logic        clock_i     = 1'b0;
  logic        reset_i     = 1'b1;
  logic        reg_write_i = 1'b0;
  logic        reg_read_i  = 1'b0;
  logic        rd_pend     = 1'b0;
  logic [3:0]  reg_addr_i  = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o, a, b, m;
  logic        issue_valid_i, issue_ready_o, done_o;
  issue_t      issue_i;
  result_t     result_o;
  note_t       eq[$];
  logic [31:0] rq[$];
  int          n_fail = 0, checks_done = 0, cyc = 0;
  op_t         dop[6] = '{packed_decimal_fix_after_sum, packed_decimal_fix_after_difference,
    unpacked_fix_after_sum, unpacked_fix_after_difference, unpacked_split_after_product,
    unpacked_merge_before_quotient};
  logic [31:0] dx[6] = '{32'h9A, 32'h9A, 32'h10C, 32'h20F, 32'h2F, 32'h407};
  logic [31:0] dv[6] = '{32'h0, 32'h34, 32'h202, 32'h109, 32'h407, 32'h2F};
  logic [31:0] dm[6] = '{32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFF};
  logic        dc[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  // ----------------------------------------
  // clock, design and decoder model
  // ----------------------------------------
  initial
  begin
    forever #2 clock_i = ~clock_i;
  end
  integer_and_bcd_arithmetic_unit dut_u (.clock_i(clock_i), .reset_i(reset_i),
    .issue_valid_i(issue_valid_i), .issue_i(issue_i), .issue_ready_o(issue_ready_o),
    .done_o(done_o), .result_o(result_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o));
  issue_source src_u (.clock_i(clock_i), .issue_ready_i(issue_ready_o),
    .issue_valid_o(issue_valid_i), .issue_o(issue_i));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_read(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask
  task automatic results();
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic op(input op_t o, input size_t s, input logic k, input logic [31:0] x, y,
                    v, vm, h, hm, input logic [5:0] f, fm);
    eq.push_back('{v, vm, h, hm, f, fm});
    src_u.send(issue_t'{o, s, k, x, y});
  endtask
  task automatic reg_acc(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i  <= ad;
    reg_wdata_i <= d;
    reg_write_i <= w;
    reg_read_i  <= !w;
    if (!w)
      rq.push_back(d);
    @(posedge clock_i);
    reg_write_i <= 1'b0;
    reg_read_i  <= 1'b0;
  endtask
  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge clock_i)
  begin
    note_t n;
    if (done_o === 1'b1 && eq.size() > 0)
    begin
      n = eq.pop_front();
      chk((result_o.write_value ? result_o.value : 32'h0) & n.vm, n.v);
      chk((result_o.write_high ? result_o.high : 32'h0) & n.hm, n.h);
      chk({26'h0, result_o.flags & n.fm}, {26'h0, n.f});
    end
    if (rd_pend && rq.size() > 0)
      chk_read(reg_rdata_o, rq.pop_front());
    rd_pend <= reg_read_i;
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      results();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h852e2a49));
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    for (int s = 0; s < 3; s++)
    begin
      m = (s == 2) ? 32'hFFFFFFFF : (32'h1 << (8 << s)) - 32'h1;
      a = $urandom;
      b = $urandom;
      op(plain_sum, size_t'(s), 0, a, b, (a + b) & m, '1, 0, 0,
         {5'h0, 33'(a & m) + 33'(b & m) > 33'(m)}, 6'h01);
      op(plain_difference, size_t'(s), 0, a, b, (a - b) & m, '1, 0, 0,
         {5'h0, (a & m) < (b & m)}, 6'h01);
    end
    op(bit_and, size_dword, 0, a, b, a & b, '1, 0, 0, 0, 0);
    op(bit_or, size_dword, 0, a, b, a | b, '1, 0, 0, 0, 0);
    op(bit_xor, size_dword, 0, a, b, a ^ b, '1, 0, 0, 0, 0);
    op(bit_invert, size_dword, 0, a, b, ~a, '1, 0, 0, 0, 0);
    op(plus_one_op, size_byte, 0, 32'hFF, 0, 0, '1, 0, 0, 6'h09, 6'h09);
    op(minus_one_op, size_byte, 0, 32'h0, 0, 32'hFF, '1, 0, 0, 6'h11, 6'h11);
    op(minus_one_op, size_word, 0, a, 0, (a - 32'h1) & 32'hFFFF, '1, 0, 0, 0, 0);
    op(sign_flip, size_dword, 0, a, 0, 32'h0 - a, '1, 0, 0, 0, 0);
    op(compare_flags_only, size_dword, 0, a, a, 0, '1, 0, 0, 6'h08, 6'h09);
    op(compare_flags_only, size_dword, 0, a, b, 0, '1, 0, 0,
       {2'h0, a == b, 2'h0, a < b}, 6'h09);
    src_u.idle();
    reg_acc(1, REG_FLAGS, 32'h3F);
    reg_acc(0, REG_FLAGS, 32'h3F);
    reg_acc(0, 4'h2, 32'h0);
    op(sum_with_carry_in, size_dword, 0, a, b, a + b + 1, '1, 0, 0, 0, 0);
    src_u.idle();
    reg_acc(0, REG_RESULT, a + b + 32'h1);
    reg_acc(1, REG_FLAGS, 32'h1);
    op(difference_with_borrow_in, size_dword, 0, a, b, a - b - 1, '1, 0, 0, 0, 0);
    for (int i = 0; i < 6; i++)
    begin
      src_u.idle();
      reg_acc(1, REG_FLAGS, 32'h0);
      op(dop[i], size_byte, 0, dx[i], 0, dv[i], dm[i], 0, 0, {5'h0, dc[i]}, 6'h01);
    end
    a = $urandom;
    b = $urandom;
    m = a[15:0] * b[15:0];
    op(unsigned_product, size_word, 0, a, b, {16'h0, m[15:0]}, '1, {16'h0, m[31:16]}, '1, 0, 0);
    op(signed_product, size_byte, 0, 32'hFD, 32'h5, 32'hF1, '1, 32'hFF, '1, 0, 0);
    op(signed_product, size_byte, 1, 32'hFD, 32'h5, 32'hF1, '1, 0, '1, 0, 0);
    b = $urandom_range(255, 1);
    op(unsigned_quotient, size_byte, 0, a, b, {24'h0, a[7:0]} / b, '1,
       {24'h0, a[7:0]} % b, '1, 0, 0);
    op(signed_quotient, size_byte, 0, 32'hF9, 32'h2, 32'hFD, '1, 32'hFF, '1, 0, 0);
    op(unsigned_quotient, size_word, 0, a, 0, 0, 0, 0, 0, 0, 0);
    src_u.idle();
    reg_acc(0, REG_STATUS, 32'h2);
    reg_acc(0, REG_RESULT_HI, 32'h0);
    for (int i = 0; i < 100 && eq.size() + rq.size() > 0; i++)
      @(posedge clock_i);
    if (eq.size() + rq.size() > 0)
      n_fail++;
    results();
  end
endmodule // test_integer_and_bcd_arithmetic_unit
